// ==== rtl/frame_cfg.svh ====
// Summary of operation
// - Each frame opens with a one-byte start marker at byte zero.
// - A 16-bit length counts the bytes between length field and checksum.
// - Last byte is 0xFF minus the low byte of the sum from byte three on.
// - Route record frames carry type code 0xA1 at byte three.
// - Route records are reported only while acting as a concentrator.
// - High-memory mode reports a node's first unicast arrival.
// - High-memory mode reports a node again after its route fails.
// - Low-memory mode reports every received transmission.
// - Options bit 6 selects high-memory or low-memory behaviour.
// - Type is followed by the 64-bit then 16-bit source address.
// - An options byte follows: bit 0 acknowledged, bit 1 broadcast.
// - A hop count follows, excluding source and destination nodes.
// - Hop addresses follow, ordered from destination toward source.
// - Registration answers carry type code 0xA4.
// - No registration frame is sent when the request identifier is zero.
// - Byte four of a registration frame echoes the request identifier.
// - Byte five holds the registration result code.
// - A reserved all-zero or all-one key reports code 0xB2 unless the install-code check also fails.
// - A failed install-code check reports the invalid security data code.
`ifndef FRAME_CFG_SVH
`define FRAME_CFG_SVH
`define SOF_BYTE        8'h7E
`define TYPE_ROUTE_REC  8'hA1
`define TYPE_REG_STATUS 8'hA4
`define CSUM_BASE       8'hFF
`define ROUTE_FIXED_LEN 16'h000D
`define REG_LEN         16'h0003
`define LOWMEM_BIT      6
`define POS_TYPE        8'h03
`define POS_HOPS        8'h10
`define ST_KEY_RESERVED 8'hB2
`define ST_CRC_FAIL     8'hBD
`endif

// ==== rtl/frame_pkg.sv ====
package frame_pkg;
   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_SEND = 1'b1} framer_state_t;
   typedef enum logic [0:0] {KIND_ROUTE = 1'b0, KIND_REG = 1'b1} frame_kind_t;
endpackage : frame_pkg

// ==== rtl/route_seen.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "frame_cfg.svh"
module route_seen
   import frame_pkg::*;
#(
   parameter int DEPTH = 16
)(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   input  wire logic [15:0] look_addr_in,
   input  wire logic        insert_in,
   input  wire logic        fail_in,
   input  wire logic [15:0] fail_addr_in,
   output logic             hit_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [15:0]      addr [DEPTH];
   logic [DEPTH-1:0] valid;
   logic [DEPTH-1:0] match;
   logic [DEPTH-1:0] fail_match;
   logic [PW-1:0]    wr_ptr;

   // One comparator pair per entry; lookup is combinational.
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_cmp
         assign match[g]      = valid[g] && (addr[g] == look_addr_in);
         assign fail_match[g] = valid[g] && (addr[g] == fail_addr_in);
      end
   endgenerate

   assign hit_out = |match;

   // Entries are replaced round-robin; an old node may be forgotten and then
   // reported again, which costs a frame but never loses a route.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         valid  <= '0;
         wr_ptr <= '0;
      end
      else if (ce_in)
      begin
         if (fail_in)
            valid <= valid & ~fail_match;
         if (insert_in)
         begin
            addr[wr_ptr]  <= look_addr_in;
            valid[wr_ptr] <= 1'b1;
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
      end
   end
endmodule : route_seen
`default_nettype wire

// ==== rtl/frame_emitter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "frame_cfg.svh"
module frame_emitter
   import frame_pkg::*;
#(
   parameter int MAX_HOPS   = 8,
   parameter int SEEN_DEPTH = 16
)(
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  ce_in,
   input  wire logic                  concentrator_in,
   input  wire logic [7:0]            misc_options_in,
   input  wire logic                  rr_valid_in,
   output logic                       rr_ready_out,
   input  wire logic                  rr_unicast_in,
   input  wire logic [63:0]           rr_ieee_in,
   input  wire logic [15:0]           rr_nwk_in,
   input  wire logic [7:0]            rr_opts_in,
   input  wire logic [7:0]            rr_hops_in,
   input  wire logic [16*MAX_HOPS-1:0] rr_hop_addr_in,
   input  wire logic                  route_fail_in,
   input  wire logic [15:0]           route_fail_addr_in,
   input  wire logic                  reg_valid_in,
   output logic                       reg_ready_out,
   input  wire logic [7:0]            reg_id_in,
   input  wire logic [7:0]            reg_result_in,
   input  wire logic                  reg_key_reserved_in,
   input  wire logic                  reg_crc_fail_in,
   output logic                       tx_valid_out,
   input  wire logic                  tx_ready_in,
   output logic [7:0]                 tx_data_out
);
   framer_state_t         state;
   frame_kind_t           kind;
   logic [7:0]            idx;
   logic [7:0]            sum;
   logic [15:0]           len;
   logic [63:0]           ieee;
   logic [15:0]           nwk;
   logic [7:0]            opts;
   logic [7:0]            hops;
   logic [16*MAX_HOPS-1:0] hop_addr;
   logic [7:0]            reg_id;
   logic [7:0]            reg_status;
   logic                  seen_hit;
   logic                  low_mem;
   logic                  rr_take;
   logic                  reg_take;
   logic                  rr_emit;
   logic                  seen_insert;
   logic                  tx_take;
   logic [7:0]            last_idx;
   logic [7:0]            next_idx;
   logic [7:0]            next_sum;
   logic [7:0]            next_byte;
   logic [7:0]            hops_clamped;
   logic [7:0]            next_status;

   // Mode select; bit set means the low-memory concentrator.
   assign low_mem = misc_options_in[`LOWMEM_BIT];

   // Registration requests win over route records when both wait, since
   // the host is stalled on its own request while route records are not.
   assign reg_ready_out = ce_in && (state == ST_IDLE);
   assign rr_ready_out  = ce_in && (state == ST_IDLE) && !reg_valid_in;
   assign reg_take      = reg_valid_in && reg_ready_out;
   assign rr_take       = rr_valid_in && rr_ready_out;
   assign tx_take       = ce_in && tx_valid_out && tx_ready_in;

   // Decide whether an arriving route record becomes a frame.
   assign rr_emit = concentrator_in
                    && (low_mem
                        || (rr_unicast_in && !seen_hit));
   assign seen_insert = rr_take && concentrator_in && rr_unicast_in
                        && !seen_hit;

   route_seen #(
      .DEPTH (SEEN_DEPTH)
   ) u_seen (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ce_in        (ce_in),
      .look_addr_in (rr_nwk_in),
      .insert_in    (seen_insert),
      .fail_in      (route_fail_in),
      .fail_addr_in (route_fail_addr_in),
      .hit_out      (seen_hit)
   );

   // Hop lists longer than the storage are cut so the frame stays honest.
   assign hops_clamped = (rr_hops_in > 8'(MAX_HOPS)) ? 8'(MAX_HOPS)
                                                      : rr_hops_in;

   // Result code: a failed check on the request overrides the key table's.
   always_comb
   begin
      if (reg_crc_fail_in)
         next_status = `ST_CRC_FAIL;
      else if (reg_key_reserved_in)
         next_status = `ST_KEY_RESERVED;
      else
         next_status = reg_result_in;
   end

   // Capture the request so the inputs may change while the frame goes out.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         kind       <= KIND_ROUTE;
         len        <= '0;
         ieee       <= '0;
         nwk        <= '0;
         opts       <= '0;
         hops       <= '0;
         hop_addr   <= '0;
         reg_id     <= '0;
         reg_status <= '0;
      end
      else if (ce_in)
      begin
         if (reg_take)
         begin
            kind       <= KIND_REG;
            len        <= `REG_LEN;
            reg_id     <= reg_id_in;
            reg_status <= next_status;
         end
         else if (rr_take)
         begin
            kind     <= KIND_ROUTE;
            len      <= `ROUTE_FIXED_LEN + {7'h00, hops_clamped, 1'b0};
            ieee     <= rr_ieee_in;
            nwk      <= rr_nwk_in;
            opts     <= rr_opts_in & 8'h03;
            hops     <= hops_clamped;
            hop_addr <= rr_hop_addr_in;
         end
      end
   end

   assign last_idx = 8'(len + 16'h0003);
   assign next_idx = idx + 8'h01;
   // Running sum including the byte now on the port, from byte three on.
   assign next_sum = (idx >= `POS_TYPE) ? sum + tx_data_out : sum;

   // Byte that follows the one on the port; fields go out high byte first.
   always_comb
   begin
      logic [7:0] hop_off;
      logic [15:0] hop_word;
      hop_off   = next_idx - `POS_HOPS;
      hop_word  = 16'(hop_addr >> (16 * hop_off[7:1]));
      next_byte = 8'h00;
      if (next_idx == last_idx)
         next_byte = `CSUM_BASE - next_sum;
      else if (next_idx == 8'h01)
         next_byte = len[15:8];
      else if (next_idx == 8'h02)
         next_byte = len[7:0];
      else if (next_idx == `POS_TYPE)
         next_byte = (kind == KIND_REG) ? `TYPE_REG_STATUS
                                         : `TYPE_ROUTE_REC;
      else if (kind == KIND_REG)
         next_byte = (next_idx == 8'h04) ? reg_id : reg_status;
      else if (next_idx <= 8'h0B)
         next_byte = 8'(ieee >> (8 * (8'h0B - next_idx)));
      else if (next_idx == 8'h0C)
         next_byte = nwk[15:8];
      else if (next_idx == 8'h0D)
         next_byte = nwk[7:0];
      else if (next_idx == 8'h0E)
         next_byte = opts;
      else if (next_idx == 8'h0F)
         next_byte = hops;
      else
         next_byte = hop_off[0] ? hop_word[7:0]
                                : hop_word[15:8];
   end

   // Frame sequencer: start on an accepted request, walk bytes on handshake.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state        <= ST_IDLE;
         idx          <= '0;
         sum          <= '0;
         tx_valid_out <= 1'b0;
         tx_data_out  <= '0;
      end
      else if (ce_in)
      begin
         case (state)
            ST_IDLE:
            begin
               if ((reg_take && (reg_id_in != 8'h00))
                   || (!reg_valid_in && rr_take && rr_emit))
               begin
                  state        <= ST_SEND;
                  idx          <= '0;
                  sum          <= '0;
                  tx_valid_out <= 1'b1;
                  tx_data_out  <= `SOF_BYTE;
               end
            end
            ST_SEND:
            begin
               if (tx_take)
               begin
                  if (idx == last_idx)
                  begin
                     state        <= ST_IDLE;
                     tx_valid_out <= 1'b0;
                  end
                  else
                  begin
                     idx         <= next_idx;
                     sum         <= next_sum;
                     tx_data_out <= next_byte;
                  end
               end
            end
            default:
            begin
               state        <= ST_IDLE;
               tx_valid_out <= 1'b0;
            end
         endcase
      end
   end

   chk_sof_first: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(tx_valid_out) |-> tx_data_out == `SOF_BYTE)
      else $error("Frame did not open with the start marker.");

   chk_type_byte: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      tx_valid_out && idx == `POS_TYPE
      |-> tx_data_out == ((kind == KIND_REG) ? `TYPE_REG_STATUS
                                             : `TYPE_ROUTE_REC))
      else $error("Frame type byte is wrong.");

   chk_reg_length: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      tx_valid_out && kind == KIND_REG && idx == 8'h02
      |-> tx_data_out == `REG_LEN)
      else $error("Registration frame length is wrong.");

   chk_checksum_sum: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      tx_valid_out && idx == last_idx
      |-> 8'(tx_data_out + sum) == `CSUM_BASE)
      else $error("Checksum does not complete the sum.");

   chk_reg_suppress: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      reg_take && reg_id_in == 8'h00 |=> !tx_valid_out)
      else $error("Frame sent for a zero identifier.");

   chk_lowmem_every: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      rr_take && concentrator_in && low_mem
      |=> tx_valid_out && tx_data_out == `SOF_BYTE)
      else $error("Low-memory route record not reported.");

   chk_needs_concentrator: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      rr_take && !concentrator_in |=> !tx_valid_out)
      else $error("Route record reported while not a concentrator.");

   chk_repeat_quiet: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      rr_take && concentrator_in && !low_mem && seen_hit |=> !tx_valid_out)
      else $error("Known node reported again in high-memory mode.");

   chk_crc_status: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      reg_take && reg_crc_fail_in |=> reg_status == `ST_CRC_FAIL)
      else $error("Install-code failure not reported.");
endmodule : frame_emitter
`default_nettype wire

// ==== verification/host_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host end of the frame stream; records bytes and can stall the sender.
module host_sink
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       slow_in,
   input  wire logic       clear_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_data_in,
   output logic            tx_ready_out
);
   logic [7:0] rx_byte [0:63];
   int         rx_count;

   // Slow mode accepts every other cycle, so the sender must hold its byte.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         tx_ready_out <= 1'b0;
      else
         tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
   end

   // Bytes are kept in arrival order, byte zero first.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rx_count <= 0;
      else if (clear_in)
         rx_count <= 0;
      else if (tx_valid_in && tx_ready_out && rx_count < 64)
      begin
         rx_byte[rx_count] <= tx_data_in;
         rx_count <= rx_count + 1;
      end
   end
endmodule : host_sink
`default_nettype wire

// ==== verification/route_record_and_registration_frames_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module route_record_and_registration_frames_tb;
   logic clk_in, rst_n_in, ce_in, conc, slow, clear;
   logic [7:0] misc, rr_opts, rr_hops, reg_id, reg_res, tx_data;
   logic rr_valid, rr_ready, rr_uni, fail, reg_valid, reg_ready;
   logic key_res, crc_fail, tx_valid, tx_ready;
   logic [63:0] rr_ieee;
   logic [15:0] rr_nwk, fail_addr;
   logic [127:0] hop_addr;
   int num_errors = 0;
   int checks_done = 0;
   typedef logic [7:0] q_t[$];
   q_t exp_q;

   frame_emitter dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .concentrator_in(conc), .misc_options_in(misc),
      .rr_valid_in(rr_valid), .rr_ready_out(rr_ready),
      .rr_unicast_in(rr_uni), .rr_ieee_in(rr_ieee), .rr_nwk_in(rr_nwk),
      .rr_opts_in(rr_opts), .rr_hops_in(rr_hops),
      .rr_hop_addr_in(hop_addr), .route_fail_in(fail),
      .route_fail_addr_in(fail_addr), .reg_valid_in(reg_valid),
      .reg_ready_out(reg_ready), .reg_id_in(reg_id),
      .reg_result_in(reg_res), .reg_key_reserved_in(key_res),
      .reg_crc_fail_in(crc_fail), .tx_valid_out(tx_valid),
      .tx_ready_in(tx_ready), .tx_data_out(tx_data));
   host_sink host_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
      .clear_in(clear), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
      .tx_ready_out(tx_ready));

   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = !clk_in;
   end

   task automatic test_done;
      $display("Counts: %0d checks, %0d mismatches", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // Checksum is worked out over bytes from position three onward.
   function automatic logic [7:0] csum(input q_t q);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 3; i < q.size(); i++)
         s = s + q[i];
      return 8'hFF - s;
   endfunction : csum

   // The byte count settles before the frame is compared, then is cleared.
   task automatic expect_frame(input q_t q);
      int i;
      i = 0;
      while (host_u.rx_count < q.size() && i < 300)
      begin
         @(posedge clk_in);
         i++;
      end
      repeat (8) @(posedge clk_in);
      `CHECK(host_u.rx_count, q.size())
      for (int k = 0; k < q.size(); k++)
         `CHECK(host_u.rx_byte[k], q[k])
      clear <= 1'b1;
      @(posedge clk_in);
      clear <= 1'b0;
   endtask : expect_frame

   // Ready is judged at the falling edge, where it has settled, so the
   // request drops right after the one edge that takes it.
   task automatic take(input logic is_reg);
      int i;
      i = 0;
      @(negedge clk_in);
      while (i < 50 && (is_reg ? reg_ready : rr_ready) !== 1'b1)
      begin
         @(negedge clk_in);
         i++;
      end
      if (i == 50)
      begin
         num_errors++;
         test_done();
      end
      @(posedge clk_in);
      reg_valid <= 1'b0;
      rr_valid <= 1'b0;
   endtask : take

   task automatic reg_req(input logic [7:0] id, res, input logic k, c);
      reg_valid <= 1'b1;
      reg_id <= id;
      reg_res <= res;
      key_res <= k;
      crc_fail <= c;
      take(1'b1);
   endtask : reg_req

   task automatic rr_req(input logic uni, input logic [15:0] nwk);
      rr_valid <= 1'b1;
      rr_uni <= uni;
      rr_nwk <= nwk;
      take(1'b0);
   endtask : rr_req

   task automatic test_reg;
      logic [7:0] codes [4] = '{8'h01, 8'h18, 8'hB1, 8'hB4};
      reg_req(8'h5D, 8'h00, 1'b0, 1'b0);
      expect_frame('{8'h7E, 8'h00, 8'h03, 8'hA4, 8'h5D, 8'h00, 8'hFE});
      foreach (codes[i])
      begin
         reg_req(8'h21 + i, codes[i], 1'b0, 1'b0);
         exp_q = '{8'h7E, 8'h00, 8'h03, 8'hA4, 8'h21 + i, codes[i]};
         exp_q.push_back(csum(exp_q));
         expect_frame(exp_q);
      end
      reg_req(8'hFF, 8'h00, 1'b1, 1'b0);
      exp_q = '{8'h7E, 8'h00, 8'h03, 8'hA4, 8'hFF, 8'hB2};
      exp_q.push_back(csum(exp_q));
      expect_frame(exp_q);
      reg_req(8'h01, 8'h00, 1'b1, 1'b1);
      exp_q = '{8'h7E, 8'h00, 8'h03, 8'hA4, 8'h01, 8'hBD};
      exp_q.push_back(csum(exp_q));
      expect_frame(exp_q);
      reg_req(8'h00, 8'h00, 1'b0, 1'b0);
      expect_frame('{});
      $display("test_reg done");
   endtask : test_reg

   // Host stalls during route frames so held bytes are exercised.
   task automatic test_route;
      q_t ex;
      ex = '{8'h7E, 8'h00, 8'h13, 8'hA1, 8'h00, 8'h13, 8'hA2, 8'h00,
             8'h12, 8'h34, 8'h56, 8'h78, 8'hDD, 8'hDD, 8'h01, 8'h03,
             8'hCC, 8'hCC, 8'hBB, 8'hBB, 8'hAA, 8'hAA, 8'h75};
      slow <= 1'b1;
      rr_req(1'b1, 16'hDDDD);
      expect_frame(ex);
      rr_req(1'b1, 16'hDDDD);
      expect_frame('{});
      rr_req(1'b0, 16'h1234);
      expect_frame('{});
      fail <= 1'b1;
      @(posedge clk_in);
      fail <= 1'b0;
      rr_req(1'b1, 16'hDDDD);
      expect_frame(ex);
      misc <= 8'h40;
      rr_req(1'b0, 16'hDDDD);
      expect_frame(ex);
      rr_req(1'b1, 16'hDDDD);
      expect_frame(ex);
      conc <= 1'b0;
      rr_req(1'b1, 16'hDDDD);
      expect_frame('{});
      $display("test_route done");
   endtask : test_route

   initial
   begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      conc = 1'b1;
      misc = 8'h00;
      slow = 1'b0;
      clear = 1'b0;
      rr_valid = 1'b0;
      rr_uni = 1'b0;
      rr_ieee = 64'h0013A20012345678;
      rr_nwk = 16'h0000;
      rr_opts = 8'h01;
      rr_hops = 8'h03;
      hop_addr = {80'h0, 16'hAAAA, 16'hBBBB, 16'hCCCC};
      fail = 1'b0;
      fail_addr = 16'hDDDD;
      reg_valid = 1'b0;
      reg_id = 8'h00;
      reg_res = 8'h00;
      key_res = 1'b0;
      crc_fail = 1'b0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      test_reg();
      test_route();
      test_done();
   end
endmodule : route_record_and_registration_frames_tb
`default_nettype wire
